// *** rtl/tdm_dev.sv ***
/*
  tdm_dev: device end. frame timing recovery from the sampled master clock
  and frame pulse, output clock and pulse generation, and a receive tap on
  one selectable backplane stream feeding a fifo read over avalon-mm.
  assumes link pins synchronous to clock and a single avalon master.
*/
`timescale 1ns/100ps
module tdm_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = count_reg != (AW+1)'(D);
  assign out_valid = count_reg != '0;
  assign out_data = mem_reg[rptr_reg];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wptr_reg <= push ? wptr_reg + 1'b1 : wptr_reg;
      rptr_reg <= pop ? rptr_reg + 1'b1 : rptr_reg;
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // tdm_fifo

// Contract
// - partner supplies the master clock
// - frame boundary on selected input clock edge
// - partner aligns input data to clock, pulse
// - frame pulse width follows width select
// - frame pulse style detected automatically
// - 8m output clock edge meets frame boundary
// - 8m output pulse one or two periods
// - output pulses once per frame, input style
// - 16m output clock edge meets frame boundary
// - 16m output pulse half or one period
// - serial outputs timed to output clocks
// - four stream rates outside 32M mode
// - each stream rate chosen independently
// - 32M mode: streams 0-15 at 32M
// - 32M mode: streams 16-31 ignored, tied
module tdm_dev import tdm_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  tdm_link_if.dev link
);
  logic [31:0] ctrl_reg;
  logic [63:0] rate_reg;
  logic mci_prev_reg;
  logic fp_seen_reg;
  logic run_lvl_reg;
  logic [2:0] run_cnt_reg;
  logic gci_reg;
  logic locked_reg;
  logic style_ok_reg;
  logic [POS_W-1:0] pos_reg;
  logic c8_reg;
  logic c16_reg;
  logic fp8_reg;
  logic fp16_reg;
  logic [31:0] bso_reg;
  logic [7:0] sh_reg;
  logic ovf_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;

  wire in_edge = ctrl_reg[CTRL_IN_EDGE];
  wire wide_sel = ctrl_reg[CTRL_WIDE];
  wire out_edge = ctrl_reg[CTRL_OUT_EDGE];
  wire mode32 = ctrl_reg[CTRL_MODE32];
  wire [4:0] sel = ctrl_reg[CTRL_SEL_LSB +: 5];

  // frame timing recovery
  wire mci = link.master_clock_input;
  wire fp_lvl = link.frame_pulse_input;
  wire mci_rise = mci & ~mci_prev_reg;
  wire mci_fall = ~mci & mci_prev_reg;
  wire sel_edge = in_edge ? mci_rise : mci_fall;
  // telephony style pulses low, gci style pulses high
  wire fp_act = gci_reg ? fp_lvl : ~fp_lvl;
  // first active edge of the pulse marks the boundary, whatever its width
  // no boundary until the idle level has named the style, else a false lock
  wire boundary = sel_edge & fp_act & ~fp_seen_reg & style_ok_reg;
  wire [POS_W-1:0] pos_next = boundary ? POS_W'(1) : pos_reg + 1'b1;
  wire same_lvl = fp_lvl == run_lvl_reg;
  wire run_done = run_cnt_reg == STYLE_RUN_MIN;

  // output pulses start on the recovered boundary, widths per select bit
  wire [POS_W-1:0] w8 = wide_sel ? FP8_WIDE_CYC : FP8_NARROW_CYC;
  wire [POS_W-1:0] w16 = wide_sel ? FP16_WIDE_CYC : FP16_NARROW_CYC;
  wire on8 = locked_reg & (pos_next < w8);
  wire on16 = locked_reg & (pos_next < w16);

  // receive tap on the selected stream
  wire [1:0] tap_rate = rate_reg[{sel, 1'b0} +: 2];
  wire [3:0] shift = tdm_bit_shift(mode32, tap_rate);
  wire [POS_W-1:0] period = POS_W'(1) << shift;
  wire [POS_W-1:0] mask = period - 1'b1;
  wire [POS_W-1:0] mid = period >> 1;
  // the boundary cycle is slot position zero, so the first bit is kept
  wire [POS_W-1:0] pos_cur = boundary ? {POS_W{1'b0}} : pos_reg;
  wire [POS_W-1:0] bitpos = pos_cur >> shift;
  wire [POS_W-1:0] chpos = bitpos >> 3;
  // upper streams carry nothing in 32M mode, whatever level is tied there
  wire tap_ok = ~(mode32 & sel[4]);
  wire hit = (locked_reg | boundary) & tap_ok & ((pos_cur & mask) == mid);
  wire [7:0] sh_next = {sh_reg[6:0], link.backplane_serial_inputs[sel]};
  wire push = hit & (bitpos[2:0] == 3'h7);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FIFO_W-1:0] fifo_out_data;

  // avalon slave, one wait state on every access
  wire req = avs_read | avs_write;
  wire acc = req & ~wait_reg;
  wire wr_acc = acc & avs_write;
  wire pop = acc & avs_read & (avs_address == REG_DATA);
  wire ovf_set = push & ~fifo_in_ready;
  wire ovf_clr = wr_acc & (avs_address == REG_STATUS) & avs_writedata[STAT_OVERFLOW];
  wire [31:0] status_word = {27'h000_0000, ovf_reg, ~fifo_in_ready, ~fifo_out_valid,
                             locked_reg, gci_reg};
  wire [31:0] data_word = {fifo_out_valid, 14'h0000, fifo_out_data};
  wire [31:0] rd_mux = (avs_address == REG_CTRL) ? ctrl_reg :
                       (avs_address == REG_RATE_LO) ? rate_reg[31:0] :
                       (avs_address == REG_RATE_HI) ? rate_reg[63:32] :
                       (avs_address == REG_STATUS) ? status_word :
                       (avs_address == REG_DATA) ? data_word : 32'h0000_0000;

  tdm_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) tdm_fifo_i (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({chpos[CHAN_W-1:0], sh_next}),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RESET;
      rate_reg <= RATE_RESET;
    end else if (wr_acc) begin
      if (avs_address == REG_CTRL) ctrl_reg <= avs_writedata;
      if (avs_address == REG_RATE_LO) rate_reg[31:0] <= avs_writedata;
      if (avs_address == REG_RATE_HI) rate_reg[63:32] <= avs_writedata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mci_prev_reg <= 1'b0;
      fp_seen_reg <= 1'b0;
      run_lvl_reg <= 1'b1;
      run_cnt_reg <= 3'h0;
      gci_reg <= 1'b0;
      locked_reg <= 1'b0;
      style_ok_reg <= 1'b0;
      pos_reg <= '0;
    end else begin
      mci_prev_reg <= mci;
      if (sel_edge) begin
        fp_seen_reg <= fp_act;
        run_lvl_reg <= fp_lvl;
        run_cnt_reg <= (same_lvl & ~run_done) ? run_cnt_reg + 1'b1 :
                       (same_lvl ? run_cnt_reg : 3'h0);
        if (same_lvl & run_done) begin
          gci_reg <= ~run_lvl_reg;
          style_ok_reg <= 1'b1;
        end
      end
      if (boundary) locked_reg <= 1'b1;
      pos_reg <= pos_next;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      c8_reg <= 1'b0;
      c16_reg <= 1'b0;
      fp8_reg <= 1'b1;
      fp16_reg <= 1'b1;
      bso_reg <= 32'h0000_0000;
    end else begin
      // built from the recovered count so its boundary edge never lags a cycle
      c8_reg <= ~(pos_next[1] ^ out_edge);
      // 16m toggles every clock, re-phased on each selected master edge
      c16_reg <= sel_edge ? out_edge : ~c16_reg;
      fp8_reg <= gci_reg ? on8 : ~on8;
      fp16_reg <= gci_reg ? on16 : ~on16;
      // retimed on the same edge as the output clocks and pulses
      bso_reg <= mode32 ? {16'h0000, link.backplane_serial_inputs[15:0]} :
                 link.backplane_serial_inputs;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sh_reg <= 8'h00;
      ovf_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (hit) sh_reg <= sh_next;
      // a drop in the same cycle as the clear still leaves the flag set
      ovf_reg <= ovf_set | (ovf_reg & ~ovf_clr);
      wait_reg <= ~(req & wait_reg);
      if (req & wait_reg) rdata_reg <= rd_mux;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign link.clock_8m_output = c8_reg;
  assign link.clock_16m_output = c16_reg;
  assign link.frame_pulse_8m_output = fp8_reg;
  assign link.frame_pulse_16m_output = fp16_reg;
  assign link.backplane_serial_outputs = bso_reg;
endmodule // tdm_dev

// *** rtl/tdm_pkg.sv ***
/*
  tdm_pkg: constants, field positions and helpers shared by both ends of the
  tdm frame timing link and by the device register map.
  assumes one 25 MHz system clock; the link is a scaled model where one
  master clock period spans four system clocks.
*/
package tdm_pkg;

  localparam int CLK_NS = 40;
  // master clock period in system clocks (scaled model of 8.192 MHz)
  localparam int MCLK_HALF_CYC = 2;
  localparam int MCLK_CYC = 2 * MCLK_HALF_CYC;
  localparam int FRAME_MCLKS = 1024;
  localparam int FRAME_CYC = FRAME_MCLKS * MCLK_CYC;
  localparam int POS_W = 12;
  localparam int STREAMS = 32;
  localparam int STREAMS_32M = 16;

  // pulse widths: 122 ns is one master period, 244 ns two, 61 ns half of one
  localparam int FP_NARROW_NS = 122;
  localparam int FP_WIDE_NS = 244;
  localparam int FP16_NARROW_NS = 61;
  localparam logic [POS_W-1:0] FP8_NARROW_CYC = POS_W'(MCLK_CYC);
  localparam logic [POS_W-1:0] FP8_WIDE_CYC = POS_W'(MCLK_CYC * FP_WIDE_NS / FP_NARROW_NS);
  localparam logic [POS_W-1:0] FP16_NARROW_CYC = POS_W'(MCLK_CYC * FP16_NARROW_NS / FP_NARROW_NS);
  localparam logic [POS_W-1:0] FP16_WIDE_CYC = FP8_NARROW_CYC;

  // consecutive equal frame pulse samples that mark the idle level
  localparam logic [2:0] STYLE_RUN_MIN = 3'h4;

  // rate codes per stream
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_16M = 2'h3;

  // register word addresses
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_RATE_LO = 3'h1;
  localparam logic [2:0] REG_RATE_HI = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_DATA = 3'h4;

  // control fields
  localparam int CTRL_IN_EDGE = 0;
  localparam int CTRL_WIDE = 1;
  localparam int CTRL_OUT_EDGE = 2;
  localparam int CTRL_MODE32 = 3;
  localparam int CTRL_SEL_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [63:0] RATE_RESET = 64'h0000_0000_0000_0000;

  // status fields
  localparam int STAT_GCI = 0;
  localparam int STAT_LOCKED = 1;
  localparam int STAT_EMPTY = 2;
  localparam int STAT_FULL = 3;
  localparam int STAT_OVERFLOW = 4;

  // data word fields
  localparam int DATA_VALID = 31;
  localparam int CHAN_W = 9;
  localparam int FIFO_W = CHAN_W + 8;
  localparam int FIFO_D = 32;

  // log2 of system clocks per bit: 32M 0, 16M 1, 8M 2, 4M 3, 2M 4
  function automatic logic [3:0] tdm_bit_shift(input logic mode32, input logic [1:0] rate);
    tdm_bit_shift = mode32 ? 4'h0 : 4'h4 - {2'h0, rate};
  endfunction

endpackage

// *** rtl/tdm_link_if.sv ***
/*
  tdm_link_if: pins between the backplane partner (host) and the device.
  assumes both ends run on the same system clock; no pin is two-way.
*/
`timescale 1ns/100ps
interface tdm_link_if;
  logic master_clock_input;
  logic frame_pulse_input;
  logic [31:0] backplane_serial_inputs;
  logic clock_8m_output;
  logic frame_pulse_8m_output;
  logic clock_16m_output;
  logic frame_pulse_16m_output;
  logic [31:0] backplane_serial_outputs;

  modport dev (
    input master_clock_input,
    input frame_pulse_input,
    input backplane_serial_inputs,
    output clock_8m_output,
    output frame_pulse_8m_output,
    output clock_16m_output,
    output frame_pulse_16m_output,
    output backplane_serial_outputs
  );

  modport host (
    output master_clock_input,
    output frame_pulse_input,
    output backplane_serial_inputs,
    input clock_8m_output,
    input frame_pulse_8m_output,
    input clock_16m_output,
    input frame_pulse_16m_output,
    input backplane_serial_outputs
  );
endinterface

// *** rtl/tdm_host.sv ***
/*
  tdm_host: backplane partner end. makes the master clock, the frame pulse
  in the chosen style and width, and 32 serial streams at per-stream rates.
  assumes the user holds its settings steady for whole frames.
*/
`timescale 1ns/100ps
module tdm_host import tdm_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic host_gci_style,
  input wire logic host_rising_edge,
  input wire logic host_wide_pulse,
  input wire logic host_mode32,
  input wire logic [63:0] host_rates,
  input wire logic [7:0] host_tx_data,
  tdm_link_if.host link
);
  logic [POS_W-1:0] hpos_reg;
  logic mci_reg;
  logic fp_reg;
  logic [31:0] bsi_reg;
  wire [31:0] bsi_next;

  wire [POS_W-1:0] hpos_next = hpos_reg + 1'b1;
  wire [POS_W-1:0] fp_w = host_wide_pulse ? FP8_WIDE_CYC : FP8_NARROW_CYC;
  wire fp_on = hpos_next < fp_w;

  // each stream carries tx data xored with its channel number, except streams 16-31 in 32M mode, held low
  genvar i;
  generate
    for (i = 0; i < STREAMS; i++) begin : g_stream
      wire [3:0] shift = tdm_bit_shift(host_mode32, host_rates[2*i +: 2]);
      wire [POS_W-1:0] bitpos = hpos_next >> shift;
      wire [POS_W-1:0] chpos = bitpos >> 3;
      wire [7:0] slot = host_tx_data ^ chpos[7:0];
      wire dead = host_mode32 & (i >= STREAMS_32M);
      assign bsi_next[i] = dead ? 1'b0 : slot[3'h7 - bitpos[2:0]];
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hpos_reg <= '0;
      mci_reg <= 1'b0;
      fp_reg <= 1'b1;
      bsi_reg <= 32'h0000_0000;
    end else begin
      hpos_reg <= hpos_next;
      // chosen edge lands where the frame count wraps
      mci_reg <= hpos_next[1] ^ host_rising_edge;
      fp_reg <= host_gci_style ? fp_on : ~fp_on;
      bsi_reg <= bsi_next;
    end
  end

  assign link.master_clock_input = mci_reg;
  assign link.frame_pulse_input = fp_reg;
  assign link.backplane_serial_inputs = bsi_reg;
endmodule // tdm_host

// *** verif/tdm_link_assertions.sv ***
/*
  tdm_link_assertions: timing checks on the device side of the link.
  assumes bench clock, reset and link signals wired in by name.
*/
`timescale 1ns/100ps
module tdm_link_assertions (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic frame_pulse_input,
  input wire logic clock_8m_output,
  input wire logic frame_pulse_8m_output,
  input wire logic clock_16m_output,
  input wire logic frame_pulse_16m_output
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [12:0] run_reg;
  logic [12:0] prev_reg;
  logic [2:0] chg_reg;
  logic last_reg;
  wire logic chg_w = frame_pulse_8m_output != last_reg;
  // first pulses after reset may be cut short, so wait for three edges
  wire logic live_w = chg_reg >= 3'h3;
  wire logic start_w = live_w && chg_w && run_reg > 13'h0064;
  always_ff @(posedge clock) begin
    last_reg <= frame_pulse_8m_output;
    if (sys_rst) begin
      run_reg <= 13'h0000;
      chg_reg <= 3'h0;
    end else if (chg_w) begin
      run_reg <= 13'h0001;
      prev_reg <= run_reg;
      chg_reg <= chg_reg + {2'h0, chg_reg != 3'h7};
    end else begin
      run_reg <= run_reg + 13'h0001;
    end
  end
  a_fp8_width: assert property (
    live_w && chg_w |-> run_reg inside {13'h0004, 13'h0008, 13'h0ff8, 13'h0ffc})
    else $error("8m pulse run wrong");
  a_frame_rate: assert property (
    chg_reg > 3'h3 && chg_w |-> run_reg + prev_reg == 13'h1000)
    else $error("frame period wrong");
  a_pulse_align: assert property (
    start_w |-> $changed(frame_pulse_16m_output))
    else $error("16m pulse start misaligned");
  a_fp16_half: assert property (
    start_w |=> ($stable(frame_pulse_16m_output) ##1 $changed(frame_pulse_16m_output)
    ##2 $changed(frame_pulse_8m_output)) or ($stable(frame_pulse_16m_output)[*3]
    ##1 $changed(frame_pulse_16m_output) ##4 $changed(frame_pulse_8m_output)))
    else $error("16m pulse width wrong");
  a_clk8_edge: assert property (
    start_w |-> $changed(clock_8m_output))
    else $error("8m clock edge off boundary");
  a_style_match: assert property (
    start_w |-> frame_pulse_8m_output == frame_pulse_input)
    else $error("output pulse style differs");
  a_clk16_toggle: assert property (
    live_w |-> clock_16m_output != $past(clock_16m_output))
    else $error("16m clock stuck");
  a_clk8_period: assert property (
    live_w && $changed(clock_8m_output) |=> $stable(clock_8m_output)
    ##1 $changed(clock_8m_output))
    else $error("8m clock period wrong");
endmodule // tdm_link_assertions

// *** verif/tdm_frame_timing_and_backplane_inputs_tb_top.sv ***
/*
  bench top: host and device joined over the link, device read over avalon.
  assumes package, interface and both ends compiled first.
*/
`timescale 1ns/100ps
module tdm_frame_timing_and_backplane_inputs_tb_top import tdm_pkg::*; ;
  logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, m;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic host_gci_style, host_rising_edge, host_wide_pulse, host_mode32;
  logic [63:0] host_rates;
  logic [7:0] host_tx_data;
  int bad_count;
  int cmp_count;
  tdm_link_if tdm_link_if_i ();
  tdm_host tdm_host_i (.clock(clock), .sys_rst(sys_rst), .host_gci_style(host_gci_style),
    .host_rising_edge(host_rising_edge), .host_wide_pulse(host_wide_pulse),
    .host_mode32(host_mode32), .host_rates(host_rates), .host_tx_data(host_tx_data),
    .link(tdm_link_if_i));
  tdm_dev tdm_dev_i (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(tdm_link_if_i));
  tdm_link_assertions tdm_link_assertions_i (.clock(clock), .sys_rst(sys_rst),
    .frame_pulse_input(tdm_link_if_i.frame_pulse_input),
    .clock_8m_output(tdm_link_if_i.clock_8m_output),
    .frame_pulse_8m_output(tdm_link_if_i.frame_pulse_8m_output),
    .clock_16m_output(tdm_link_if_i.clock_16m_output),
    .frame_pulse_16m_output(tdm_link_if_i.frame_pulse_16m_output));
  always #(CLK_NS / 2) clock = ~clock;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // waitrequest and readdata are registers, read at the edge before it updates them
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdat = avs_readdata;
    chk({31'h0, avs_waitrequest}, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic cfg(input logic g, input logic e, input logic w, input logic [1:0] r,
      input int s);
    logic [63:0] rt;
    rt = {32{r + 2'h1}};
    rt[2 * s +: 2] = r;
    sys_rst <= 1'b1;
    host_gci_style <= g;
    host_rising_edge <= e;
    host_wide_pulse <= w;
    host_mode32 <= m;
    host_rates <= rt;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    av(1'b1, REG_CTRL, {19'h0, s[4:0], 4'h0, m, e, w, e});
    av(1'b1, REG_RATE_LO, rt[31:0]);
    av(1'b1, REG_RATE_HI, rt[63:32]);
  endtask
  task automatic drain(input int cnt);
    int prev;
    prev = 0;
    for (int i = 0; i < 32; i++) begin
      av(1'b0, REG_DATA, 32'h0);
      chk({31'h0, rdat[DATA_VALID] && {23'h0, rdat[16:8]} < cnt}, 32'h1);
      chk({24'h0, rdat[7:0] ^ rdat[15:8]}, {24'h0, host_tx_data});
      if (i > 0 && i < 16) chk({23'h0, rdat[16:8]}, (prev + 1) % cnt);
      prev = rdat[16:8];
    end
  endtask
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata, m} = '0;
    {host_gci_style, host_rising_edge, host_wide_pulse, host_mode32, host_rates} = '0;
    host_tx_data = 8'ha5;
    bad_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int a = 0; a < 3; a++) begin
      av(1'b0, 3'(a), 32'h0);
      chk(rdat, 32'h0);
    end
    av(1'b1, 3'h6, 32'hffff_ffff);
    av(1'b0, 3'h6, 32'h0);
    chk(rdat, 32'h0);
    // every input style, edge, width and rate once, then the fixed fast mode
    for (int k = 0; k < 5; k++) begin
      m = k == 4;
      cfg(k[0], k[1], k[0] ^ k[1], k[1:0], m ? 3 : k * 7);
      repeat (3 * FRAME_CYC) @(posedge clock);
      av(1'b0, REG_STATUS, 32'h0);
      chk({27'h0, rdat[4:0]}, {27'h0, 3'h6, 1'b1, k[0]});
      drain(m ? 512 : 32 << k);
      // serial outputs are the inputs one clock later
      @(posedge clock) rdat = tdm_link_if_i.backplane_serial_inputs;
      @(posedge clock) chk(tdm_link_if_i.backplane_serial_outputs,
          m ? rdat & 32'h0000_ffff : rdat);
      if (m) chk({16'h0, tdm_link_if_i.backplane_serial_outputs[31:16]}, 32'h0);
    end
    av(1'b1, REG_CTRL, 32'h0000_1408);
    for (int i = 0; i < 34; i++) av(1'b0, REG_DATA, 32'h0);
    chk({31'h0, rdat[DATA_VALID]}, 32'h0);
    av(1'b1, REG_STATUS, 32'h0000_0010);
    av(1'b0, REG_STATUS, 32'h0);
    chk({29'h0, rdat[4:2]}, 32'h1);
    tally_and_finish();
  end
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end
endmodule // tdm_frame_timing_and_backplane_inputs_tb_top
